// ===== src/tsc_axil_regs.sv
/*
  AXI4-Lite slave holding the controller's own registers.
  Assumes one system clock; the sequencer supplies the status and pixel index words.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.svh"
module tsc_axil_regs
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // AXI4-Lite
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Register contents and status
  output logic [31:0] o_ctrl,
  output logic [31:0] o_cfg,
  output logic [31:0] o_integ,
  output logic [31:0] o_read,
  input wire logic [31:0] i_status,
  input wire logic [31:0] i_pixel
);
  logic aw_reg;
  logic w_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_reg;
  logic [31:0] integ_reg;
  logic [31:0] read_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  wire do_write = aw_reg && w_reg && !bvalid_reg;
  wire wr_hit = (awaddr_reg == `TSC_REG_CTRL) || (awaddr_reg == `TSC_REG_CFG) ||
    (awaddr_reg == `TSC_REG_INTEG) || (awaddr_reg == `TSC_REG_READ);
  wire do_read = i_arvalid && !rvalid_reg;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [31:0] wmask;

  // ==========================================================================
  // Handshakes
  assign o_awready = !aw_reg;
  assign o_wready = !w_reg;
  assign o_arready = !rvalid_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_ctrl = ctrl_reg;
  assign o_cfg = cfg_reg;
  assign o_integ = integ_reg;
  assign o_read = read_reg;

  // Byte mask and read selection
  always_comb
  begin
    wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    rd_hit = 1'b1;
    case (i_araddr)
      `TSC_REG_CTRL: rd_mux = ctrl_reg;
      `TSC_REG_CFG: rd_mux = cfg_reg;
      `TSC_REG_INTEG: rd_mux = integ_reg;
      `TSC_REG_READ: rd_mux = read_reg;
      `TSC_REG_STATUS: rd_mux = i_status;
      `TSC_REG_PIXEL: rd_mux = i_pixel;
      default:
      begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write path; control bits are one-cycle pulses
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      ctrl_reg <= 32'h0;
      cfg_reg <= 32'h0000_00cc;
      integ_reg <= 32'h0000_1000;
      read_reg <= 32'h0000_009f;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end
    else
    begin
      ctrl_reg <= 32'h0;
      if (i_awvalid && !aw_reg)
      begin
        aw_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end
      if (i_wvalid && !w_reg)
      begin
        w_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (do_write)
      begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
        if (awaddr_reg == `TSC_REG_CTRL)
          ctrl_reg <= wdata_reg & wmask;
        if (awaddr_reg == `TSC_REG_CFG)
          cfg_reg <= (cfg_reg & ~wmask) | (wdata_reg & wmask);
        if (awaddr_reg == `TSC_REG_INTEG)
          integ_reg <= (integ_reg & ~wmask) | (wdata_reg & wmask);
        if (awaddr_reg == `TSC_REG_READ)
          read_reg <= (read_reg & ~wmask) | (wdata_reg & wmask);
      end
      else if (bvalid_reg && i_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Read path
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end
    else if (do_read)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (rvalid_reg && i_rready)
      rvalid_reg <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== src/tsc_defines.svh
/*
  Constants of the time-of-flight sensor controller: register offsets,
  latch bit positions, timing counts at a 200 MHz system clock.
  Assumes inclusion by its bare name from design files under src/.
*/
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define TSC_REG_CTRL 8'h00
`define TSC_REG_CFG 8'h04
`define TSC_REG_INTEG 8'h08
`define TSC_REG_READ 8'h0c
`define TSC_REG_STATUS 8'h10
`define TSC_REG_PIXEL 8'h14

// ==========================================================================
// Control bits
`define TSC_CTRL_INIT 0
`define TSC_CTRL_FRAME 1
`define TSC_CTRL_PDOWN 2

// ==========================================================================
// Latch bit positions
`define TSC_ROW_PD0 0
`define TSC_ROW_TESTCOL 1
`define TSC_ROW_GAIN_LO 2
`define TSC_ROW_DRIVE 4
`define TSC_ROW_SLEW 5
`define TSC_ROW_PD7 7
`define TSC_COL_REV_ROW 5
`define TSC_COL_INIT 6
`define TSC_COL_REV_COL 7
`define TSC_INIT_ROW_WORD 8'h00
`define TSC_INIT_COL_WORD 8'h40
`define TSC_GAIN_BYPASS 2'h3

// ==========================================================================
// Timing: figures and derived cycle counts at 200 MHz
`define TSC_CLK_MHZ 200
`define TSC_POWERUP_MS 5
`define TSC_POWERUP_CYC (`TSC_POWERUP_MS * 1000 * `TSC_CLK_MHZ)
`define TSC_SUBS_FLUSH_NS 100
`define TSC_SUBS_FLUSH_CYC ((`TSC_SUBS_FLUSH_NS * `TSC_CLK_MHZ + 999) / 1000)
`define TSC_PIX_FLUSH_US 5
`define TSC_PIX_FLUSH_CYC (`TSC_PIX_FLUSH_US * `TSC_CLK_MHZ)
`define TSC_RESET_US 5
`define TSC_RESET_CYC (`TSC_RESET_US * `TSC_CLK_MHZ)
`define TSC_GAP_NS 100
`define TSC_GAP_CYC ((`TSC_GAP_NS * `TSC_CLK_MHZ + 999) / 1000)
`define TSC_LATCH_CYC 4
`define TSC_COL_HALF_CYC 4
`define TSC_ROW_HALF_CYC 200
`define TSC_INIT_COUNTS 256
`define TSC_COL_LAST 8'h9f
`define TSC_MIN_COLS 80

`endif

// ===== src/tsc_pkg.sv
/*
  Types of the time-of-flight sensor controller.
  Assumes tsc_defines.svh for all numeric constants.
*/
package tsc_pkg;
  // Sequencer states, one-hot
  typedef enum logic [9:0]
  {
    ST_IDLE = 10'h001,
    ST_LATCH = 10'h002,
    ST_INIT = 10'h004,
    ST_SUBS = 10'h008,
    ST_GAP = 10'h010,
    ST_DRAIN = 10'h020,
    ST_RESET = 10'h040,
    ST_INTEG = 10'h080,
    ST_CLOSE = 10'h100,
    ST_READ = 10'h200
  } tsc_state_e;
endpackage

// ===== src/tsc_sequencer.sv
/*
  Companion controller for a time-of-flight image sensor: drives the latch
  strobe, row and column address buses, mix pair, shutter, pixel drain and
  core reset. Software orders it through AXI4-Lite registers.
  Assumes the sensor has no clock; every timing is a minimum count here.
*/
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.svh"
module tsc_sequencer
#(
  parameter int POWERUP_CYC = `TSC_POWERUP_CYC
)
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Supply good from board
  input wire logic i_supply_good,
  // AXI4-Lite
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Sensor pins
  output logic o_latch_strobe,
  output logic [7:0] o_row_addr,
  output logic [7:0] o_col_addr,
  output logic [1:0] o_mix_drive_pair,
  output logic o_shutter,
  output logic o_pixel_drain,
  output logic o_core_reset,
  // Sample timing to the converter
  output logic o_sample_valid,
  output logic [8:0] o_first_pixel,
  output logic [8:0] o_second_pixel
);
  logic [31:0] ctrl;
  logic [31:0] cfg;
  logic [31:0] integ;
  logic [31:0] readcfg;
  logic [31:0] status;
  logic [31:0] pixel;
  tsc_pkg::tsc_state_e state_reg;
  tsc_pkg::tsc_state_e state_next;
  tsc_pkg::tsc_state_e after_latch_reg;
  logic sup_meta_reg;
  logic sup_sync_reg;
  logic [31:0] pwr_cnt_reg;
  logic pwr_ok_reg;
  logic [31:0] cnt_reg;
  logic [15:0] latch_word_reg;
  logic strobe_reg;
  logic [7:0] row_reg;
  logic [7:0] col_reg;
  logic [1:0] mix_reg;
  logic shutter_reg;
  logic drain_reg;
  logic core_reg;
  logic init_done_reg;
  logic data_valid_reg;
  logic pdown_reg;
  logic [8:0] init_cnt_reg;
  logic [7:0] row_last_reg;
  logic [7:0] col_last_reg;
  logic sample_reg;
  logic [8:0] px1_reg;
  logic [8:0] px2_reg;
  logic busy_err_reg;
  logic half_reg;

  // ==========================================================================
  // Register configuration fields
  wire [1:0] gain_sel = cfg[3:2];
  wire gain_active = gain_sel != `TSC_GAIN_BYPASS;
  wire fast_slew = cfg[`TSC_ROW_SLEW];
  wire double_drive = cfg[`TSC_ROW_DRIVE] && !fast_slew;
  wire test_cols = cfg[`TSC_ROW_TESTCOL];
  wire rev_row = cfg[8 + `TSC_COL_REV_ROW];
  wire rev_col = cfg[8 + `TSC_COL_REV_COL];
  wire [31:0] integ_cyc = (integ == 32'h0) ? 32'h1 : integ;
  wire [7:0] col_stop_req = readcfg[7:0] > `TSC_COL_LAST ? `TSC_COL_LAST : readcfg[7:0];
  // Gain modes need at least 80 columns
  wire [7:0] col_stop = (gain_active && col_stop_req < 8'(`TSC_MIN_COLS - 1)) ?
    8'(`TSC_MIN_COLS - 1) : col_stop_req;
  wire [7:0] row_stop = readcfg[15:8];
  wire go_init = ctrl[`TSC_CTRL_INIT];
  wire go_frame = ctrl[`TSC_CTRL_FRAME];
  wire go_pdown = ctrl[`TSC_CTRL_PDOWN];
  wire busy = state_reg != tsc_pkg::ST_IDLE;
  wire accept = !busy && pwr_ok_reg;
  // Run latch word: reserved bits zero, power down on both row bits
  wire [7:0] run_row = {pdown_reg, 1'b0, fast_slew, double_drive, gain_sel,
    test_cols, pdown_reg};
  wire [7:0] run_col = {rev_col, 1'b0, rev_row, 5'h0};
  // Column phase: one toggle period = two half periods
  wire col_half_end = cnt_reg == 32'(`TSC_COL_HALF_CYC - 1);
  // Row and column phases restart the counter every half period
  wire cnt_wrap = (state_reg == tsc_pkg::ST_READ && col_half_end) ||
    (state_reg == tsc_pkg::ST_INIT && cnt_reg == 32'(`TSC_ROW_HALF_CYC - 1));
  wire row_end = col_reg == col_stop;
  wire last_row = row_reg == row_stop;
  // Row-zero dummy columns are read but flagged only when gain path active
  wire row0_dummy = gain_active && row_reg == 8'h0;

  // ==========================================================================
  // Pin drivers
  assign o_latch_strobe = strobe_reg;
  assign o_row_addr = row_reg;
  assign o_col_addr = col_reg;
  assign o_mix_drive_pair = mix_reg;
  assign o_shutter = shutter_reg;
  assign o_pixel_drain = drain_reg;
  assign o_core_reset = core_reg;
  assign o_sample_valid = sample_reg;
  assign o_first_pixel = px1_reg;
  assign o_second_pixel = px2_reg;
  assign status = {18'h0, busy_err_reg, pdown_reg, data_valid_reg, init_done_reg,
    pwr_ok_reg, busy, state_reg[7:0]};
  assign pixel = {8'h0, row_last_reg, 7'h0, px1_reg};

  // Register slave
  tsc_axil_regs u_regs
  (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_ctrl(ctrl),
    .o_cfg(cfg),
    .o_integ(integ),
    .o_read(readcfg),
    .i_status(status),
    .i_pixel(pixel)
  );

  // ==========================================================================
  // Supply good synchroniser and power-up wait
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sup_meta_reg <= 1'b0;
      sup_sync_reg <= 1'b0;
      pwr_cnt_reg <= 32'h0;
      pwr_ok_reg <= 1'b0;
    end
    else
    begin
      sup_meta_reg <= i_supply_good;
      sup_sync_reg <= sup_meta_reg;
      if (!sup_sync_reg)
      begin
        pwr_cnt_reg <= 32'h0;
        pwr_ok_reg <= 1'b0;
      end
      else if (pwr_cnt_reg >= 32'(POWERUP_CYC - 1))
        pwr_ok_reg <= 1'b1;
      else
        pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
    end
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      tsc_pkg::ST_IDLE:
        if (accept && (go_init || go_frame || go_pdown))
          state_next = tsc_pkg::ST_LATCH;
      tsc_pkg::ST_LATCH:
        if (cnt_reg == 32'(2 * `TSC_LATCH_CYC - 1))
          state_next = after_latch_reg;
      tsc_pkg::ST_INIT:
        if (init_cnt_reg == 9'(`TSC_INIT_COUNTS) && cnt_reg == 32'h0)
          state_next = tsc_pkg::ST_IDLE;
      tsc_pkg::ST_SUBS:
        if (cnt_reg == 32'(`TSC_SUBS_FLUSH_CYC - 1))
          state_next = tsc_pkg::ST_GAP;
      tsc_pkg::ST_GAP:
        if (cnt_reg == 32'(`TSC_GAP_CYC - 1))
          state_next = tsc_pkg::ST_DRAIN;
      tsc_pkg::ST_DRAIN:
        if (cnt_reg == 32'(`TSC_PIX_FLUSH_CYC - 1))
          state_next = tsc_pkg::ST_RESET;
      tsc_pkg::ST_RESET:
        if (cnt_reg == 32'(`TSC_RESET_CYC - 1))
          state_next = tsc_pkg::ST_INTEG;
      tsc_pkg::ST_INTEG:
        if (cnt_reg == integ_cyc - 32'h1)
          state_next = tsc_pkg::ST_CLOSE;
      tsc_pkg::ST_CLOSE:
        if (cnt_reg == 32'(`TSC_GAP_CYC - 1))
          state_next = tsc_pkg::ST_READ;
      tsc_pkg::ST_READ:
        if (col_half_end && half_reg && row_end && last_row)
          state_next = tsc_pkg::ST_IDLE;
      default:
        state_next = tsc_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================================
  // State, counter and latch word
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= tsc_pkg::ST_IDLE;
      after_latch_reg <= tsc_pkg::ST_IDLE;
      cnt_reg <= 32'h0;
      latch_word_reg <= 16'h0;
      pdown_reg <= 1'b0;
      busy_err_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg || cnt_wrap) ? 32'h0 : cnt_reg + 32'h1;
      if (busy && (go_init || go_frame || go_pdown))
        busy_err_reg <= 1'b1;
      else if (state_reg == tsc_pkg::ST_IDLE && state_next == tsc_pkg::ST_LATCH)
      begin
        busy_err_reg <= 1'b0;
        pdown_reg <= go_pdown;
        if (go_init)
        begin
          latch_word_reg <= {`TSC_INIT_COL_WORD, `TSC_INIT_ROW_WORD};
          after_latch_reg <= tsc_pkg::ST_INIT;
        end
        else if (go_pdown)
        begin
          latch_word_reg <= {run_col, run_row | 8'h81};
          after_latch_reg <= tsc_pkg::ST_IDLE;
        end
        else
        begin
          latch_word_reg <= {run_col, run_row};
          after_latch_reg <= tsc_pkg::ST_SUBS;
        end
      end
    end
  end

  // ==========================================================================
  // Pin sequencing: strobe, buses, mix, shutter, drain, core reset
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strobe_reg <= 1'b0;
      row_reg <= 8'h0;
      col_reg <= 8'h0;
      mix_reg <= 2'h0;
      shutter_reg <= 1'b0;
      drain_reg <= 1'b1;
      core_reg <= 1'b0;
      init_cnt_reg <= 9'h0;
      init_done_reg <= 1'b0;
      data_valid_reg <= 1'b0;
      half_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        tsc_pkg::ST_LATCH:
        begin
          // Data set up while strobe high, taken on its fall
          strobe_reg <= cnt_reg < 32'(`TSC_LATCH_CYC);
          {col_reg, row_reg} <= latch_word_reg;
          if (after_latch_reg == tsc_pkg::ST_INIT)
          begin
            init_done_reg <= 1'b0;
            init_cnt_reg <= 9'h0;
          end
        end
        tsc_pkg::ST_INIT:
        begin
          strobe_reg <= 1'b0;
          col_reg <= 8'h0;
          // Count 256 row changes at the row half period
          if (cnt_reg == 32'(`TSC_ROW_HALF_CYC - 1) || cnt_reg == 32'h0)
          begin
            if (cnt_reg != 32'h0 && init_cnt_reg != 9'(`TSC_INIT_COUNTS))
            begin
              row_reg <= row_reg + 8'h1;
              init_cnt_reg <= init_cnt_reg + 9'h1;
            end
          end
          if (init_cnt_reg == 9'(`TSC_INIT_COUNTS))
            init_done_reg <= 1'b1;
        end
        tsc_pkg::ST_SUBS:
        begin
          strobe_reg <= 1'b0;
          shutter_reg <= 1'b1;
          mix_reg <= 2'h3;
          core_reg <= 1'b1;
        end
        tsc_pkg::ST_GAP, tsc_pkg::ST_RESET:
        begin
          mix_reg <= 2'h0;
          drain_reg <= 1'b1;
        end
        tsc_pkg::ST_DRAIN:
        begin
          mix_reg <= 2'h0;
          drain_reg <= 1'b0;
          core_reg <= 1'b1;
        end
        tsc_pkg::ST_INTEG:
        begin
          // Complementary modulation at half the system clock
          mix_reg <= (mix_reg == 2'h1) ? 2'h2 : 2'h1;
          shutter_reg <= 1'b1;
          core_reg <= 1'b0;
        end
        tsc_pkg::ST_CLOSE:
        begin
          mix_reg <= 2'h0;
          shutter_reg <= (cnt_reg == 32'h0);
          row_reg <= 8'h0;
          col_reg <= 8'h0;
        end
        tsc_pkg::ST_READ:
        begin
          // Column address steps every full period; mix pair stays idle low
          mix_reg <= 2'h0;
          if (col_half_end)
          begin
            half_reg <= ~half_reg;
            if (half_reg)
            begin
              col_reg <= row_end ? 8'h0 : col_reg + 8'h1;
              if (row_end)
                row_reg <= row_reg + 8'h1;
            end
          end
          data_valid_reg <= init_done_reg;
        end
        default:
        begin
          strobe_reg <= 1'b0;
          mix_reg <= 2'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pixel index of each column word for the converter
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sample_reg <= 1'b0;
      px1_reg <= 9'h0;
      px2_reg <= 9'h0;
      row_last_reg <= 8'h0;
      col_last_reg <= 8'h0;
    end
    else
    begin
      sample_reg <= state_reg == tsc_pkg::ST_READ && col_half_end && !half_reg &&
        init_done_reg && !row0_dummy;
      if (state_reg == tsc_pkg::ST_READ && col_half_end && !half_reg)
      begin
        px1_reg <= {1'b0, col_reg[7:3], 3'h0} + {1'b0, col_reg[7:3], 3'h0} +
          {6'h0, col_reg[2:0]};
        px2_reg <= {1'b0, col_reg[7:3], 3'h0} + {1'b0, col_reg[7:3], 3'h0} +
          {6'h0, col_reg[2:0]} + 9'h8;
        row_last_reg <= row_reg;
        col_last_reg <= col_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/* Testbench of tsc_sequencer over AXI4-Lite.
   Assumes the sensor model on the pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_supply_good = 1'b1;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0, o_row_addr, o_col_addr, row_l, col_l;
  logic [31:0] i_wdata = 32'h0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hf;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_latch_strobe, o_shutter;
  logic o_pixel_drain, o_core_reset, o_sample_valid, pd, byp, init_ok;
  logic [1:0] o_bresp, o_rresp, o_mix_drive_pair, r;
  logic [8:0] o_first_pixel, o_second_pixel;
  int fail_count = 0, total_checks = 0, n_samp = 0, s0;
  // Clock and sample counter
  always #2.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys)
    if (o_sample_valid === 1'b1)
      n_samp <= n_samp + 1;
  tsc_sequencer #(.POWERUP_CYC(50)) dut (.i_clk_sys, .i_reset_n, .i_supply_good, .i_awaddr,
    .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
    .o_latch_strobe, .o_row_addr, .o_col_addr, .o_mix_drive_pair, .o_shutter, .o_pixel_drain,
    .o_core_reset, .o_sample_valid, .o_first_pixel, .o_second_pixel);
  tsc_sensor_model u_sensor (.i_strobe(o_latch_strobe), .i_row(o_row_addr), .i_col(o_col_addr),
    .o_row_latch(row_l), .o_col_latch(col_l), .o_power_down(pd), .o_bypass(byp),
    .o_init_ok(init_ok));
  // ======
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      @(posedge i_clk_sys);
      if (o_awready)
        i_awvalid <= 1'b0;
      if (o_wready)
        i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
      @(posedge i_clk_sys);
    while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    while (o_rvalid !== 1'b1)
      @(posedge i_clk_sys);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask
  task automatic idle();
    do
      rd(8'h10);
    while (d[8] !== 1'b0);
  endtask
  task automatic frame(input logic [31:0] cfg, input logic [31:0] rdw, input int n);
    wr(8'h04, cfg);
    wr(8'h0c, rdw);
    s0 = n_samp;
    wr(8'h00, 32'h2);
    idle();
    chk(n_samp - s0, n);
  endtask
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #450000;
    fail_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(8'h04);
    chk(d, 32'hcc);
    rd(8'h08);
    chk(d, 32'h1000);
    rd(8'h18);
    chk({r, d[29:0]}, 32'h80000000);
    do
      rd(8'h10);
    while (d[9] !== 1'b1);
    wr(8'h00, 32'h1);
    idle();
    chk({row_l, col_l}, 32'h40);
    chk(init_ok, 1'b1);
    frame(32'ha030, 32'h0105, 80);
    chk({col_l, row_l}, 32'ha020);
    frame(32'h000c, 32'h0105, 12);
    chk(byp, 1'b1);
    wr(8'h04, 32'h000e);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h2);
    idle();
    chk(d[13], 1'b1);
    chk(row_l[1], 1'b1);
    wr(8'h00, 32'h4);
    idle();
    chk(pd, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire

// ===== verif/tsc_sensor_model.sv
/* Behavioural sensor latches and init count.
   Assumes the sequencer's strobe and address pins. */
`timescale 1ns/1ps
`default_nettype none
module tsc_sensor_model
(
  // Sensor pins
  input wire logic i_strobe,
  input wire logic [7:0] i_row,
  input wire logic [7:0] i_col,
  // Latched state
  output logic [7:0] o_row_latch,
  output logic [7:0] o_col_latch,
  output logic o_power_down,
  output logic o_bypass,
  output logic o_init_ok
);
  int init_cnt = 0;
  // Capture at strobe fall
  always @(negedge i_strobe)
  begin
    o_row_latch <= i_row;
    o_col_latch <= i_col & 8'he0;
    if (i_col[6])
      init_cnt <= 0;
  end
  // Row steps of the init period
  always @(i_row)
    if (!i_strobe && init_cnt < 256)
      init_cnt <= init_cnt + 1;
  assign o_init_ok = init_cnt == 256;
  assign o_power_down = o_row_latch[0] | o_row_latch[7];
  assign o_bypass = &o_row_latch[3:2];
endmodule
`default_nettype wire

// ===== verif/tsc_seq_assertions.sv
/* Checker on the sensor pins of tsc_sequencer.
   Assumes one clock and bind by port name. */
`timescale 1ns/1ps
`default_nettype none
module tsc_seq_assertions
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Sensor pins and sample timing to the converter
  input wire logic o_latch_strobe,
  input wire logic [7:0] o_row_addr,
  input wire logic [7:0] o_col_addr,
  input wire logic [1:0] o_mix_drive_pair,
  input wire logic o_shutter,
  input wire logic o_pixel_drain,
  input wire logic o_core_reset,
  input wire logic o_sample_valid,
  input wire logic [8:0] o_first_pixel,
  input wire logic [8:0] o_second_pixel
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [10:0] low_cnt;
  // Both mix high, and integration pattern
  wire flush = &o_mix_drive_pair;
  wire integ = o_shutter & ^o_mix_drive_pair;
  // Drain low cycle count
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
    if (!i_reset_n)
      low_cnt <= 11'h0;
    else
      low_cnt <= o_pixel_drain ? 11'h0 : low_cnt + 11'h1;
  // ======
  // Properties
  AST_LATCH: assert property ($rose(o_latch_strobe) |-> o_latch_strobe[*4] ##1 !o_latch_strobe)
    else $error("strobe width wrong");
  AST_RSVD: assert property (o_latch_strobe |-> !o_row_addr[6] && o_col_addr[4:0] == 5'h0)
    else $error("reserved latch bit set");
  AST_SHUT: assert property ($rose(o_shutter) |-> flush)
    else $error("shutter opened without flush");
  AST_SUBS: assert property ($fell(flush) |-> $past(flush, 20))
    else $error("substrate flush short");
  AST_DRAIN: assert property (!o_pixel_drain |-> o_core_reset && o_mix_drive_pair == 2'h0)
    else $error("drain low without core reset");
  AST_DRLEN: assert property ($rose(o_pixel_drain) |-> low_cnt == 11'h3e8 && !flush)
    else $error("drain low length wrong");
  AST_COMP: assert property ($past(integ) && o_shutter |-> !flush)
    else $error("mix not complementary");
  AST_CLOSE: assert property ($fell(o_shutter) |-> $past(o_mix_drive_pair) == 2'h0)
    else $error("shutter closed before mix idle");
  AST_PIX: assert property (o_sample_valid |-> o_second_pixel == o_first_pixel + 9'h8)
    else $error("second pixel index wrong");
  AST_PIXMAP: assert property (o_sample_valid |-> o_first_pixel[2:0] == o_col_addr[2:0] &&
    !o_first_pixel[3] && o_first_pixel[8:4] == o_col_addr[7:3])
    else $error("first pixel index does not follow column word");
  cover property (o_sample_valid);
  cover property ($rose(o_pixel_drain));
  cover property ($fell(o_latch_strobe));
endmodule
bind tsc_sequencer tsc_seq_assertions u_chk (.i_clk_sys, .i_reset_n, .o_latch_strobe,
  .o_row_addr, .o_col_addr, .o_mix_drive_pair, .o_shutter, .o_pixel_drain, .o_core_reset,
  .o_sample_valid, .o_first_pixel, .o_second_pixel);
`default_nettype wire
